// ---- design/qdt_defs.svh ----
// Purpose: register offsets, field positions, reset values, timing counts
// Assumes: byte addresses on a 32-bit classic wishbone slave
// Notes:   definitions only
`ifndef QDT_DEFS_SVH
`define QDT_DEFS_SVH

`define QDT_OFS_CONTROL   8'h00
`define QDT_OFS_CONFIG    8'h04
`define QDT_OFS_COUNTER   8'h08
`define QDT_OFS_WRAP      8'h0c
`define QDT_OFS_MATCH     8'h10
`define QDT_OFS_SNAPSHOT  8'h14
`define QDT_OFS_FLAG      8'h18
`define QDT_OFS_FLAG_CLR  8'h1c
`define QDT_OFS_IRQ_VIEW  8'h20
`define QDT_OFS_IRQ_SET   8'h24
`define QDT_OFS_IRQ_CLR   8'h28
`define QDT_OFS_PARAM     8'h2c
`define QDT_OFS_VERSION   8'h30

// control_reg
`define QDT_CTL_ENABLE    0
`define QDT_CTL_START     1
// config_reg
`define QDT_CFG_DECODER   0
`define QDT_CFG_IDX_RST   1
`define QDT_CFG_POS_CMP   2
`define QDT_CFG_REV_CMP   3
`define QDT_CFG_EVT_START 4
`define QDT_CFG_INV_A     8
`define QDT_CFG_INV_B     9
`define QDT_CFG_INV_IDX   10
`define QDT_CFG_IDX_PHS   11
`define QDT_CFG_DEGLITCH  13
`define QDT_CFG_TSENSE    16
`define QDT_CFG_BIDIR     17
`define QDT_CFG_MASK      32'h00033f1f
// flag_reg
`define QDT_FLG_INDEX     0
`define QDT_FLG_MATCH     1
`define QDT_FLG_CAPTURE   2
`define QDT_FLG_POS_WRAP  3
`define QDT_FLG_REV_WRAP  4
`define QDT_FLG_IDX_ERR   5
`define QDT_FLG_DIR_FLIP  6
`define QDT_FLG_LOST      7
`define QDT_FLG_ILLEGAL   8
`define QDT_FLG_TRIGGER   9
`define QDT_FLG_SENSE     16
`define QDT_FLG_RUNNING   17
`define QDT_NUM_FLAGS     10

`define QDT_RST_WORD      32'h00000000
`define QDT_DEGLITCH_HOLD 2'd3

`endif

// ---- design/qdt_pkg.sv ----
// Purpose: types shared by the quadrature decoder / timer
// Assumes: qdt_defs.svh holds the numbers
// Notes:   none
package qdt_pkg;

	typedef struct packed {
		logic        cyc;
		logic        stb;
		logic        we;
		logic [3:0]  sel;
		logic [7:0]  adr;
		logic [31:0] dat;
	} qdt_wb_req_t;

	typedef struct packed {
		logic phase_a_input;
		logic phase_b_input;
		logic index_input;
	} qdt_enc_t;

	typedef struct packed {
		logic trigger;
		logic capture;
		logic toggle_dir;
	} qdt_evt_t;

	typedef enum logic [1:0] {
		QDT_STEP_NONE = 2'b00,
		QDT_STEP_UP   = 2'b01,
		QDT_STEP_DOWN = 2'b10,
		QDT_STEP_BAD  = 2'b11
	} qdt_step_t;

endpackage

// ---- design/qdt_top.sv ----
// Purpose: quadrature decoder with alternative 32-bit up/down timer
// Assumes: encoder pins asynchronous; events and debug_i on clk_i
// Notes:   internal count clock is a clock enable derived by a divider
//
// The Wishbone slave port is this design's own decision.
`include "qdt_defs.svh"

// Function
// RL1 - capture event copies counter into snapshot only while counter runs
// RL2 - capture before snapshot read keeps old value, sets capture_lost
// RL3 - with deglitch_en, inputs pass after three stable count clock ticks
// RL4 - decoder_mode_sel zero selects 32-bit timer with compare and capture
// RL5 - timer reuses counter, limit, compare, snapshot; skips filters, index
// RL6 - timer with bidir_timer_en reverses direction on each toggle event
// RL7 - timer_initial_sense loads on trigger; count_sense shows live sense
// RL8 - timer counting down stays at zero while direction is down
// RL9 - one interrupt line fed by ten status sources
// RL10 - snapshot read in debug keeps the pending capture record
// RL11 - timer position wrap on ffff with rc not limit, pc or rc limit
// RL12 - index mismatch when pc is not limit going up, not one down
// RL13 - non-adjacent phase jump raises illegal_step_flag
// RL14 - enable set and clear registers; irq_mask_view shows enables
// RL15 - flags set regardless of mask; cleared by writing one to clear
// RL16 - trigger starts counting, capture snapshots, toggle acts in timer
// RL17 - compare event emitted when counter reaches match value
// RL18 - soft_start triggers only while unit_enable; reads back zero
// RL19 - unit_enable zero stops unit and count clock, one enables
// RL20 - index_phase_sel picks phase state A,B that arms index detection
// RL21 - config bits invert phase A, phase B and index inputs
// RL22 - router triggers honoured only when event_start_en is one
// RL23 - any trigger resets counter and starts the count clock
// RL24 - index_reset_en with index in chosen phase zeroes position
// RL25 - decoder_mode_sel one selects quadrature decoding
// RL26 - match enables choose revolution, position or full compare
// RL27 - snapshot read outside debug marks snapshot read
module qdt_top
	import qdt_pkg::*;
#(
	parameter int          COUNT_DIV   = 4,
	parameter logic [31:0] PARAM_WORD  = 32'h00000000,
	parameter logic [31:0] VERSION_ID  = 32'h00000100
)(
	// clock, reset, freeze
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	input  wire logic        ce_i,
	// register bus
	input  wire qdt_wb_req_t wb_i,
	output logic [31:0]      wb_dat_o,
	output logic             wb_ack_o,
	// encoder pins and event router
	input  wire qdt_enc_t    enc_i,
	input  wire qdt_evt_t    evt_i,
	input  wire logic        debug_i,
	output logic             cmp_evt_o,
	output logic             irq_o
);

	// version value is arbitrary
	localparam int DW = $clog2(COUNT_DIV + 1);

	logic [31:0] ctl_cfg_r;
	logic        enable_r;
	logic [31:0] cnt_r;
	logic [31:0] cnt_nxt;
	logic [31:0] top_r;
	logic [31:0] match_r;
	logic [31:0] snap_r;
	logic        unread_r;
	logic [`QDT_NUM_FLAGS-1:0] flags_r;
	logic [`QDT_NUM_FLAGS-1:0] flag_set;
	logic [`QDT_NUM_FLAGS-1:0] mask_r;
	logic        running_r;
	logic        down_r;
	logic        down_nxt;
	logic        hit_r;
	logic [DW-1:0] div_r;
	logic        tick;
	logic [2:0]  sync1_r;
	logic [2:0]  sync2_r;
	logic [2:0]  filt_r;
	logic [2:0]  line;
	logic [1:0]  phase_r;
	logic        idx_arm_r;
	logic        bus_go;
	logic        wr;
	logic        rd;
	logic        trig;
	logic        timer;
	logic        hit;
	logic [15:0] pc;
	logic [15:0] rc;
	logic [15:0] pc_top;
	logic [15:0] rc_top;
	logic        idx_hit;
	qdt_step_t   step;

	function automatic logic [31:0] merge(input logic [31:0] old,
		input logic [31:0] nw, input logic [3:0] sel);
		logic [31:0] m;
		m = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
		return (old & ~m) | (nw & m);
	endfunction

	function automatic logic wr_at(input logic [7:0] ofs);
		return wr && (wb_i.adr == ofs);
	endfunction

	// next state along the positive sense, A leading B
	function automatic qdt_step_t decode(input logic [1:0] prv,
		input logic [1:0] cur);
		logic [1:0] fwd;
		fwd = {~prv[0], prv[1]};
		if (prv == cur)
			return QDT_STEP_NONE;
		else if ((prv ^ cur) == 2'b11)
			return QDT_STEP_BAD;
		else if (cur == fwd)
			return QDT_STEP_UP;
		else
			return QDT_STEP_DOWN;
	endfunction

	assign bus_go = wb_i.cyc && wb_i.stb && !wb_ack_o;
	assign wr     = bus_go && wb_i.we;
	assign rd     = bus_go && !wb_i.we;
	assign timer  = !ctl_cfg_r[`QDT_CFG_DECODER]; // RL4 RL25
	assign pc     = cnt_r[15:0];
	assign rc     = cnt_r[31:16];
	assign pc_top = top_r[15:0];
	assign rc_top = top_r[31:16];
	assign tick   = running_r && (div_r == DW'(COUNT_DIV - 1));

	// trigger sources
	always_comb begin
		trig = 1'b0;
		if (enable_r && wr_at(`QDT_OFS_CONTROL) && wb_i.sel[0]
			&& wb_i.dat[`QDT_CTL_START])
			trig = 1'b1; // RL18
		if (enable_r && evt_i.trigger && ctl_cfg_r[`QDT_CFG_EVT_START])
			trig = 1'b1; // RL22
	end

	// internal count clock divider
	always_ff @(posedge clk_i) begin
		if (rst_i || !running_r)
			div_r <= '0;
		else if (ce_i)
			div_r <= tick ? '0 : DW'(div_r + 1'b1);
	end

	always_ff @(posedge clk_i) begin
		if (rst_i)
			running_r <= 1'b0;
		else if (ce_i) begin
			if (!enable_r)
				running_r <= 1'b0; // RL19
			else if (trig)
				running_r <= 1'b1; // RL16 RL23
		end
	end

	// pin synchronisers, polarity, deglitch
	assign line = sync2_r ^ {ctl_cfg_r[`QDT_CFG_INV_A],
		ctl_cfg_r[`QDT_CFG_INV_B], ctl_cfg_r[`QDT_CFG_INV_IDX]}; // RL21

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			sync1_r <= 3'h0;
			sync2_r <= 3'h0;
		end else if (ce_i) begin
			sync1_r <= {enc_i.phase_a_input, enc_i.phase_b_input,
				enc_i.index_input};
			sync2_r <= sync1_r;
		end
	end

	genvar gi;
	generate
		for (gi = 0; gi < 3; gi++) begin : g_filt
			logic [1:0] hold_r;
			always_ff @(posedge clk_i) begin
				if (rst_i) begin
					hold_r     <= 2'h0;
					filt_r[gi] <= 1'b0;
				end else if (ce_i) begin
					if (!ctl_cfg_r[`QDT_CFG_DEGLITCH]) begin
						hold_r     <= 2'h0;
						filt_r[gi] <= line[gi];
					end else if (line[gi] == filt_r[gi])
						hold_r <= 2'h0;
					else if (tick) begin
						if (hold_r == `QDT_DEGLITCH_HOLD - 2'd1) begin
							hold_r     <= 2'h0;
							filt_r[gi] <= line[gi]; // RL3
						end else
							hold_r <= hold_r + 2'd1;
					end
				end
			end
		end
	endgenerate

	assign step    = decode(phase_r, filt_r[2:1]);
	// index armed only in the chosen phase, edge counted once
	assign idx_hit = !timer && filt_r[0] && !idx_arm_r
		&& (filt_r[2:1] == ctl_cfg_r[`QDT_CFG_IDX_PHS +: 2]); // RL20

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			phase_r   <= 2'h0;
			idx_arm_r <= 1'b0;
		end else if (ce_i) begin
			phase_r   <= filt_r[2:1];
			idx_arm_r <= filt_r[0]
				&& (filt_r[2:1] == ctl_cfg_r[`QDT_CFG_IDX_PHS +: 2]);
		end
	end

	// counter, direction and event flags
	always_comb begin
		cnt_nxt  = cnt_r;
		down_nxt = down_r;
		flag_set = '0;
		if (trig) begin
			cnt_nxt  = 32'h0; // RL23
			flag_set[`QDT_FLG_TRIGGER] = 1'b1;
			if (timer)
				down_nxt = ctl_cfg_r[`QDT_CFG_TSENSE]; // RL7
		end else if (wr_at(`QDT_OFS_COUNTER))
			cnt_nxt = merge(cnt_r, wb_i.dat, wb_i.sel);
		else if (running_r && timer) begin // RL5
			if (evt_i.toggle_dir && ctl_cfg_r[`QDT_CFG_BIDIR])
				down_nxt = !down_r; // RL6 RL16
			if (tick && !down_r) begin
				if ((pc == 16'hffff && rc != rc_top) || pc == pc_top
					|| rc == rc_top)
					flag_set[`QDT_FLG_POS_WRAP] = 1'b1; // RL11
				cnt_nxt = (cnt_r == top_r) ? 32'h0 : cnt_r + 32'h1;
			end else if (tick && cnt_r != 32'h0)
				cnt_nxt = cnt_r - 32'h1; // RL8
		end else if (running_r) begin
			if (step == QDT_STEP_BAD)
				flag_set[`QDT_FLG_ILLEGAL] = 1'b1; // RL13
			else if (step == QDT_STEP_UP) begin
				down_nxt = 1'b0;
				if (pc == pc_top) begin
					cnt_nxt[15:0] = 16'h0;
					flag_set[`QDT_FLG_POS_WRAP] = 1'b1;
					flag_set[`QDT_FLG_REV_WRAP] = (rc == rc_top);
					cnt_nxt[31:16] = (rc == rc_top) ? 16'h0 : rc + 16'h1;
				end else
					cnt_nxt[15:0] = pc + 16'h1;
			end else if (step == QDT_STEP_DOWN) begin
				down_nxt = 1'b1;
				if (pc == 16'h0) begin
					cnt_nxt[15:0] = pc_top;
					flag_set[`QDT_FLG_POS_WRAP] = 1'b1;
					flag_set[`QDT_FLG_REV_WRAP] = (rc == 16'h0);
					cnt_nxt[31:16] = (rc == 16'h0) ? rc_top : rc - 16'h1;
				end else
					cnt_nxt[15:0] = pc - 16'h1;
			end
			if (idx_hit) begin
				flag_set[`QDT_FLG_INDEX] = 1'b1;
				if (down_r ? (pc != 16'h1) : (pc != pc_top))
					flag_set[`QDT_FLG_IDX_ERR] = 1'b1; // RL12
				if (ctl_cfg_r[`QDT_CFG_IDX_RST])
					cnt_nxt[15:0] = 16'h0; // RL24
			end
		end
		if (down_nxt != down_r)
			flag_set[`QDT_FLG_DIR_FLIP] = 1'b1;
		if (hit && !hit_r)
			flag_set[`QDT_FLG_MATCH] = 1'b1;
		if (evt_i.capture && running_r) begin
			if (unread_r)
				flag_set[`QDT_FLG_LOST] = 1'b1; // RL2
			else
				flag_set[`QDT_FLG_CAPTURE] = 1'b1;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cnt_r  <= `QDT_RST_WORD;
			down_r <= 1'b0;
		end else if (ce_i) begin
			cnt_r  <= cnt_nxt;
			down_r <= down_nxt;
		end
	end

	// compare on chosen halves; neither enabled means never
	always_comb begin
		hit = ctl_cfg_r[`QDT_CFG_POS_CMP] || ctl_cfg_r[`QDT_CFG_REV_CMP];
		if (ctl_cfg_r[`QDT_CFG_POS_CMP] && pc != match_r[15:0])
			hit = 1'b0; // RL26
		if (ctl_cfg_r[`QDT_CFG_REV_CMP] && rc != match_r[31:16])
			hit = 1'b0; // RL26
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			hit_r     <= 1'b0;
			cmp_evt_o <= 1'b0;
		end else if (ce_i) begin
			hit_r     <= hit;
			cmp_evt_o <= hit && !hit_r; // RL17
		end
	end

	// snapshot; a read clears the pending mark unless halted in debug
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			snap_r   <= `QDT_RST_WORD;
			unread_r <= 1'b0;
		end else if (ce_i) begin
			if (evt_i.capture && running_r && !unread_r) begin
				snap_r   <= cnt_r; // RL1
				unread_r <= 1'b1;
			end else if (rd && wb_i.adr == `QDT_OFS_SNAPSHOT && !debug_i)
				unread_r <= 1'b0; // RL10 RL27
		end
	end

	// status: hardware set wins over a same-cycle clear
	always_ff @(posedge clk_i) begin
		if (rst_i)
			flags_r <= '0;
		else if (ce_i) begin
			if (wr_at(`QDT_OFS_FLAG_CLR))
				flags_r <= (flags_r & ~wb_i.dat[`QDT_NUM_FLAGS-1:0])
					| flag_set; // RL15
			else
				flags_r <= flags_r | flag_set; // RL15
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i)
			mask_r <= '0;
		else if (ce_i) begin
			if (wr_at(`QDT_OFS_IRQ_SET))
				mask_r <= mask_r | wb_i.dat[`QDT_NUM_FLAGS-1:0]; // RL14
			else if (wr_at(`QDT_OFS_IRQ_CLR))
				mask_r <= mask_r & ~wb_i.dat[`QDT_NUM_FLAGS-1:0]; // RL14
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i)
			irq_o <= 1'b0;
		else if (ce_i)
			irq_o <= |(flags_r & mask_r); // RL9
	end

	// control and configuration
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			enable_r  <= 1'b0;
			ctl_cfg_r <= `QDT_RST_WORD;
			top_r     <= `QDT_RST_WORD;
			match_r   <= `QDT_RST_WORD;
		end else if (ce_i) begin
			if (wr_at(`QDT_OFS_CONTROL) && wb_i.sel[0])
				enable_r <= wb_i.dat[`QDT_CTL_ENABLE]; // RL19
			if (wr_at(`QDT_OFS_CONFIG))
				ctl_cfg_r <= merge(ctl_cfg_r, wb_i.dat, wb_i.sel)
					& `QDT_CFG_MASK;
			if (wr_at(`QDT_OFS_WRAP))
				top_r <= merge(top_r, wb_i.dat, wb_i.sel);
			if (wr_at(`QDT_OFS_MATCH))
				match_r <= merge(match_r, wb_i.dat, wb_i.sel);
		end
	end

	// bus answer one cycle after the request; unmapped reads zero
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h0;
		end else if (ce_i) begin
			wb_ack_o <= bus_go;
			wb_dat_o <= 32'h0;
			if (rd) begin
				case (wb_i.adr)
					`QDT_OFS_CONTROL:  wb_dat_o <= {31'h0, enable_r}; // RL18
					`QDT_OFS_CONFIG:   wb_dat_o <= ctl_cfg_r;
					`QDT_OFS_COUNTER:  wb_dat_o <= cnt_r;
					`QDT_OFS_WRAP:     wb_dat_o <= top_r;
					`QDT_OFS_MATCH:    wb_dat_o <= match_r;
					`QDT_OFS_SNAPSHOT: wb_dat_o <= snap_r;
					`QDT_OFS_FLAG: begin
						wb_dat_o <= {22'h0, flags_r};
						wb_dat_o[`QDT_FLG_SENSE]   <= down_r; // RL7
						wb_dat_o[`QDT_FLG_RUNNING] <= running_r;
					end
					`QDT_OFS_IRQ_VIEW: wb_dat_o <= {22'h0, mask_r}; // RL14
					`QDT_OFS_PARAM:    wb_dat_o <= PARAM_WORD;
					`QDT_OFS_VERSION:  wb_dat_o <= VERSION_ID;
					default:           wb_dat_o <= 32'h0;
				endcase
			end
		end
	end

endmodule

// ---- tb/qdt_top_props.sv ----
// Purpose: port-level timing checks for qdt_top
// Assumes: sees only the top module's ports
// Notes:   bound to every qdt_top instance
module qdt_top_props
	import qdt_pkg::*;
#(
	parameter int COUNT_DIV = 4
)(
	// clock, reset, freeze
	input wire logic        clk_i,
	input wire logic        rst_i,
	input wire logic        ce_i,
	// register bus
	input wire qdt_wb_req_t wb_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic        wb_ack_o,
	// pins and events
	input wire qdt_enc_t    enc_i,
	input wire qdt_evt_t    evt_i,
	input wire logic        debug_i,
	input wire logic        cmp_evt_o,
	input wire logic        irq_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	wire take = wb_i.cyc && wb_i.stb && !wb_ack_o && ce_i;

	property p_ack_next;
		take |=> wb_ack_o;
	endproperty
	a_ack_next: assert property (p_ack_next)
		else $error("no ack after request");
	property p_ack_once;
		wb_ack_o && ce_i |=> !wb_ack_o;
	endproperty
	a_ack_once: assert property (p_ack_once)
		else $error("ack longer than one cycle");
	property p_ack_cause;
		wb_ack_o |-> $past(take);
	endproperty
	a_ack_cause: assert property (p_ack_cause)
		else $error("ack without request");
	property p_dat_idle;
		!wb_ack_o |-> wb_dat_o == 32'h0;
	endproperty
	a_dat_idle: assert property (p_dat_idle)
		else $error("read data outside ack");
	property p_soft_zero;
		wb_ack_o && !$past(wb_i.we) && $past(wb_i.adr) == 8'h00
			|-> !wb_dat_o[1];
	endproperty
	a_soft_zero: assert property (p_soft_zero)
		else $error("soft start reads one");
	property p_hole;
		wb_ack_o && $past(wb_i.adr) > 8'h30 |-> wb_dat_o == 32'h0;
	endproperty
	a_hole: assert property (p_hole)
		else $error("unmapped read not zero");
	property p_cmp_pulse;
		cmp_evt_o |=> !cmp_evt_o;
	endproperty
	a_cmp_pulse: assert property (p_cmp_pulse)
		else $error("compare event too long");
	// all enables cleared leaves no source for the line
	property p_irq_off;
		wb_ack_o && $past(wb_i.we) && $past(wb_i.adr) == 8'h28
			&& $past(wb_i.dat) == 32'hffffffff |-> ##2 !irq_o;
	endproperty
	a_irq_off: assert property (p_irq_off)
		else $error("irq with all enables off");
endmodule

bind qdt_top qdt_top_props #(.COUNT_DIV(COUNT_DIV)) i_props (
	.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .wb_i(wb_i),
	.wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .enc_i(enc_i),
	.evt_i(evt_i), .debug_i(debug_i), .cmp_evt_o(cmp_evt_o),
	.irq_o(irq_o));

// ---- tb/qdt_enc_model.sv ----
// Purpose: incremental encoder driving phase and index pins
// Assumes: one state step per request, levels held between steps
// Notes:   jump_i skips a state to make an illegal pair change
module qdt_enc_model
	import qdt_pkg::*;
(
	// requests from the bench
	input  wire logic clk_i,
	input  wire logic step_i,
	input  wire logic up_i,
	input  wire logic jump_i,
	input  wire logic idx_i,
	// encoder pins
	output qdt_enc_t  enc_o
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [1:0] st_r = 2'd0;
	always_ff @(posedge clk_i) begin
		if (jump_i)
			st_r <= st_r + 2'd2;
		else if (step_i)
			st_r <= up_i ? st_r + 2'd1 : st_r - 2'd1;
	end
	// a leads b going up: 00,10,11,01
	assign enc_o.phase_a_input = ^st_r;
	assign enc_o.phase_b_input = st_r[1];
	assign enc_o.index_input   = idx_i;
endmodule

// ---- tb/tb_quadrature_decoder_timer.sv ----
// Purpose: self-checking bench for the decoder / timer
// Assumes: count clock divider of 2 keeps the run short
// Notes:   counter windows allow for bus latency
`include "qdt_defs.svh"
module tb_quadrature_decoder_timer import qdt_pkg::*;;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [31:0] VER = 32'h00000a5a; // arbitrary value
	logic        clk_i = 1'b0;
	logic        rst_i = 1'b1;
	qdt_wb_req_t wb_i = '0;
	qdt_evt_t    evt_i = '0;
	logic        debug_i = 1'b0;
	logic        step = 1'b0;
	logic        up = 1'b1;
	logic        jump = 1'b0;
	logic        idx = 1'b0;
	qdt_enc_t    enc;
	logic [31:0] wb_dat_o;
	logic        wb_ack_o;
	logic        cmp_evt_o;
	logic        irq_o;
	logic [31:0] lfsr = 32'h0036;
	logic [31:0] q;
	logic [31:0] s;
	int          failures = 0;
	int          checks = 0;
	int          mask_m = 0;
	int          n;

	always #4 clk_i = ~clk_i;
	qdt_enc_model i_enc (.clk_i(clk_i), .step_i(step), .up_i(up),
		.jump_i(jump), .idx_i(idx), .enc_o(enc));
	qdt_top #(.COUNT_DIV(2), .VERSION_ID(VER)) i_dut (
		.clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1), .wb_i(wb_i),
		.wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .enc_i(enc),
		.evt_i(evt_i), .debug_i(debug_i), .cmp_evt_o(cmp_evt_o),
		.irq_o(irq_o));

	function automatic logic [31:0] rnd();
		lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
		return lfsr;
	endfunction
	task automatic give_verdict();
		$display("checks %0d failures %0d", checks, failures);
		if (failures == 0 && checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		checks++;
		if (g !== e) begin
			failures++;
			$display("[ERR] %0t got %h exp %h", $time, g, e);
		end
	endtask
	// hold the request until ack is sampled, then release
	task automatic xf(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		int k;
		k = 0;
		@(posedge clk_i);
		wb_i <= '{1'b1, 1'b1, w, 4'hf, a, d};
		do begin
			@(posedge clk_i);
			k++;
		end while (wb_ack_o !== 1'b1 && k < 40);
		q = wb_dat_o;
		wb_i <= '0;
		if (k >= 40) begin
			failures++;
			give_verdict();
		end
	endtask
	task automatic rc(input logic [7:0] a, input logic [31:0] e);
		xf(1'b0, a, 32'h0);
		chk(q, e);
	endtask
	task automatic rf(input logic [31:0] m, input logic [31:0] e);
		xf(1'b0, `QDT_OFS_FLAG, 32'h0);
		chk(q & m, e);
	endtask
	task automatic clr();
		xf(1'b1, `QDT_OFS_FLAG_CLR, 32'h3ff);
	endtask
	task automatic ev(input logic [2:0] b);
		@(posedge clk_i);
		evt_i <= b;
		@(posedge clk_i);
		evt_i <= '0;
	endtask
	// slow steps so the synchroniser always catches them
	task automatic stp(input logic u, input logic j);
		@(posedge clk_i);
		step <= ~j;
		jump <= j;
		up <= u;
		@(posedge clk_i);
		step <= 1'b0;
		jump <= 1'b0;
		repeat (16) @(posedge clk_i);
	endtask

	initial begin
		repeat (16) @(posedge clk_i);
		rst_i <= 1'b0;
		for (int a = 0; a <= 'h34; a += 4)
			rc(8'(a), a == 'h30 ? VER : 32'h0);
		chk({31'h0, irq_o}, 32'h0);
		$display("end reset");
		s = rnd() & 32'h3ff;
		xf(1'b1, `QDT_OFS_IRQ_SET, s);
		mask_m = s & ~32'h5;
		xf(1'b1, `QDT_OFS_IRQ_CLR, 32'h5);
		rc(`QDT_OFS_IRQ_VIEW, mask_m);
		xf(1'b1, `QDT_OFS_IRQ_CLR, 32'hffffffff);
		mask_m = 0;
		rc(`QDT_OFS_IRQ_VIEW, 32'h0);
		s = rnd();
		xf(1'b1, `QDT_OFS_CONFIG, s);
		rc(`QDT_OFS_CONFIG, s & `QDT_CFG_MASK);
		xf(1'b1, `QDT_OFS_CONFIG, 32'h0);
		$display("end registers");
		xf(1'b1, `QDT_OFS_CONTROL, 32'h2);
		rf(32'h20200, 32'h0);
		xf(1'b1, `QDT_OFS_WRAP, 32'hffffffff);
		xf(1'b1, `QDT_OFS_CONTROL, 32'h1);
		xf(1'b1, `QDT_OFS_COUNTER, 32'h12345678);
		xf(1'b1, `QDT_OFS_CONTROL, 32'h3);
		rc(`QDT_OFS_CONTROL, 32'h1);
		xf(1'b0, `QDT_OFS_COUNTER, 32'h0);
		chk({31'h0, q < 32'h40}, 32'h1);
		rf(32'h30200, 32'h20200);
		xf(1'b1, `QDT_OFS_COUNTER, 32'h0001fffe);
		repeat (12) @(posedge clk_i);
		xf(1'b0, `QDT_OFS_COUNTER, 32'h0);
		chk({31'h0, q > 32'h1ffff && q < 32'h20020}, 32'h1);
		rf(32'h8, 32'h8);
		$display("end timer");
		clr();
		ev(3'h2);
		repeat (40) @(posedge clk_i);
		ev(3'h2);
		xf(1'b0, `QDT_OFS_SNAPSHOT, 32'h0);
		s = q;
		xf(1'b0, `QDT_OFS_COUNTER, 32'h0);
		chk({31'h0, s + 32'd15 < q}, 32'h1);
		rf(32'h84, 32'h84);
		clr();
		ev(3'h2);
		rf(32'h84, 32'h4);
		debug_i <= 1'b1;
		xf(1'b0, `QDT_OFS_SNAPSHOT, 32'h0);
		debug_i <= 1'b0;
		clr();
		ev(3'h2);
		rf(32'h80, 32'h80);
		xf(1'b1, `QDT_OFS_CONTROL, 32'h0);
		clr();
		ev(3'h2);
		rf(32'h20004, 32'h0);
		$display("end capture");
		xf(1'b1, `QDT_OFS_CONFIG, 32'h10000);
		xf(1'b1, `QDT_OFS_CONTROL, 32'h1);
		xf(1'b1, `QDT_OFS_CONTROL, 32'h3);
		rf(32'h10000, 32'h10000);
		repeat (20) @(posedge clk_i);
		rc(`QDT_OFS_COUNTER, 32'h0);
		xf(1'b1, `QDT_OFS_CONFIG, 32'h30000);
		xf(1'b1, `QDT_OFS_CONTROL, 32'h3);
		clr();
		ev(3'h1);
		rf(32'h10040, 32'h40);
		repeat (20) @(posedge clk_i);
		xf(1'b0, `QDT_OFS_COUNTER, 32'h0);
		chk({31'h0, q > 32'h5}, 32'h1);
		ev(3'h1);
		rf(32'h10000, 32'h10000);
		$display("end direction");
		xf(1'b1, `QDT_OFS_CONFIG, 32'h0);
		clr();
		ev(3'h4);
		rf(32'h200, 32'h0);
		xf(1'b1, `QDT_OFS_CONFIG, 32'h10);
		ev(3'h4);
		rf(32'h200, 32'h200);
		$display("end events");
		xf(1'b1, `QDT_OFS_IRQ_SET, 32'h2);
		mask_m = 2;
		xf(1'b1, `QDT_OFS_CONFIG, 32'hc);
		xf(1'b1, `QDT_OFS_MATCH, 32'h20);
		xf(1'b1, `QDT_OFS_CONTROL, 32'h3);
		clr();
		for (n = 0; n < 200 && cmp_evt_o !== 1'b1; n++)
			@(posedge clk_i);
		chk({31'h0, cmp_evt_o}, 32'h1);
		rf(32'h2, 32'h2);
		chk({31'h0, irq_o}, 32'(mask_m[1]));
		xf(1'b1, `QDT_OFS_FLAG_CLR, 32'h2);
		repeat (2) @(posedge clk_i);
		chk({31'h0, irq_o}, 32'h0);
		$display("end compare");
		xf(1'b1, `QDT_OFS_WRAP, 32'hff);
		xf(1'b1, `QDT_OFS_CONFIG, 32'h1);
		xf(1'b1, `QDT_OFS_CONTROL, 32'h3);
		repeat (3) stp(1'b1, 1'b0);
		rc(`QDT_OFS_COUNTER, 32'h3);
		stp(1'b0, 1'b0);
		rc(`QDT_OFS_COUNTER, 32'h2);
		clr();
		stp(1'b1, 1'b1);
		rf(32'h100, 32'h100);
		xf(1'b1, `QDT_OFS_CONFIG, 32'h101);
		xf(1'b1, `QDT_OFS_CONTROL, 32'h3);
		xf(1'b1, `QDT_OFS_COUNTER, 32'h10);
		repeat (2) stp(1'b1, 1'b0);
		rc(`QDT_OFS_COUNTER, 32'he);
		$display("end decoder");
		// pins rest at a=1,b=1; dropping inv a steps down once
		xf(1'b1, `QDT_OFS_CONFIG, 32'h1803);
		xf(1'b1, `QDT_OFS_COUNTER, 32'h5);
		clr();
		@(posedge clk_i);
		idx <= 1'b1;
		repeat (8) @(posedge clk_i);
		rc(`QDT_OFS_COUNTER, 32'h0);
		rf(32'h21, 32'h21);
		rf(32'h1, 32'h1);
		@(posedge clk_i);
		idx <= 1'b0;
		$display("end index");
		give_verdict();
	end
endmodule
